// ### hdl/lics_pkg.sv
// Constants and carrier types for the lithium charge sequencer.
// Assumes a single 125 MHz clock; all analog results arrive as comparator levels.
package lics_pkg;

    localparam int unsigned CLK_MHZ          = 125;
    localparam int unsigned IMMUNITY_US      = 200;
    localparam int unsigned TERM_DELAY_US    = 500;
    localparam int unsigned PRECHARGE_HRS    = 2;
    localparam int unsigned IMMUNITY_CYC     = IMMUNITY_US * CLK_MHZ;
    localparam int unsigned TERM_DELAY_CYC   = TERM_DELAY_US * CLK_MHZ;
    localparam int unsigned US_PER_SEC       = 1000000;
    localparam int unsigned SEC_PER_HR       = 3600;
    localparam int unsigned SEC_TICK_CYC     = CLK_MHZ * US_PER_SEC;
    localparam int unsigned PRECHARGE_SEC    = PRECHARGE_HRS * SEC_PER_HR;
    // Fast timer selections in hours: 20, 5, 8, 12
    localparam int unsigned FAST_SEC_SEL0    = 20 * SEC_PER_HR;
    localparam int unsigned FAST_SEC_SEL1    = 5 * SEC_PER_HR;
    localparam int unsigned FAST_SEC_SEL2    = 8 * SEC_PER_HR;
    localparam int unsigned FAST_SEC_SEL3    = 12 * SEC_PER_HR;
    localparam logic [1:0]  TJ_REG_RST       = 2'h3;
    localparam logic [1:0]  PRE_CUR_RST      = 2'h1;
    localparam logic [4:0]  FAST_CUR_RST     = 5'h07;
    localparam logic [5:0]  FULL_V_RST       = 6'h23;
    localparam logic [1:0]  TERM_CUR_RST     = 2'h1;
    localparam int unsigned FAST_CUR_MSB     = 4;

    typedef enum logic [2:0] {
        LICS_IDLE  = 3'b000,
        LICS_PRE   = 3'b001,
        LICS_FAST  = 3'b010,
        LICS_CV    = 3'b011,
        LICS_DONE  = 3'b100,
        LICS_FAULT = 3'b101
    } lics_phase_e;

    // Analog comparator results, all asynchronous to sys_clk
    typedef struct packed {
        logic in_undervoltage_lockout_ok;
        logic in_ovp;
        logic batt_undervoltage_lockout_ok;
        logic batt_above_pre;
        logic batt_at_full;
        logic batt_ovp;
        logic batt_below_rech;
        logic cur_below_term;
        logic cv_dominant;
        logic sys_below_batt30;
        logic sys_above_batt20;
        logic tj_at_reg;
        logic tj_shutdown;
        logic ntc_fault;
        logic in_limiting;
    } lics_cmp_s;

    // Host-programmed charge settings
    typedef struct packed {
        logic       charge_enable;
        logic       timer_enable;
        logic       sw_reset;
        logic       cutoff_enable;
        logic       done_without_cutoff;
        logic       double_timer_enable;
        logic       battery_fet_force_off;
        logic [1:0] fast_timer_sel;
        logic [1:0] precharge_current;
        logic [4:0] fast_current;
        logic [5:0] full_charge_voltage;
        logic [1:0] term_current;
        logic [1:0] tj_reg_sel;
    } lics_cfg_s;

    typedef struct packed {
        logic       input_path_fet;
        logic       battery_fet;
        logic       battery_fet_full_on;
        logic       supplement_mode;
        logic       discharge_mode;
        logic       cc_mode;
        logic       cv_mode;
        logic       reduce_current;
        logic [1:0] current_field;
        logic [4:0] fast_current;
        logic [5:0] full_charge_voltage;
        logic [2:0] term_threshold;
        logic [1:0] tj_reg_sel;
    } lics_drv_s;

    typedef struct packed {
        logic        charging;
        logic        charge_done;
        logic        timeout_fault;
        logic        batt_ovp_fault;
        logic        thermal_fault;
        logic        input_fault;
        lics_phase_e phase;
    } lics_sts_s;

    function automatic logic [31:0] lics_fast_limit(input logic [1:0] sel);
        case (sel)
            2'h0:    lics_fast_limit = FAST_SEC_SEL0;
            2'h1:    lics_fast_limit = FAST_SEC_SEL1;
            2'h2:    lics_fast_limit = FAST_SEC_SEL2;
            default: lics_fast_limit = FAST_SEC_SEL3;
        endcase
    endfunction

endpackage

// ### hdl/lics_sequencer.sv
// Charge phase sequencer for a single-cell lithium charger.
// Assumes settings come from a host register block already in sys_clk domain
// and comparator results come straight from analog and need synchronising.
//
// Functional notes
// - Supply above lockout resets all settings, host ready
// - Input out of range turns input FET off
// - Input must stay good through 200us immunity
// - Below pre-charge threshold apply pre-charge current
// - Pre-charge over two hours gives timeout fault
// - Above pre-charge threshold enter fast charge
// - At full voltage switch to constant voltage
// - Termination threshold halved for low fast current
// - Terminate after 500us at threshold in CV
// - Cutoff and done bits select termination behaviour
// - Fast timer expiry before termination gives timeout
// - Power recycle, enable or recharge start cycle
// - Charging needs no NTC, timer, OVER_VOLTAGE_PROTECTION fault, FET on
// - Auto-recharge below margin only with cutoff mode
// - Battery 120mV over full voltage suspends, faults
// - Supplement on at 30mV below, off 20mV above
// - No input means discharge, battery FET fully on
// - Junction at regulation threshold reduces charge current
// - Junction at 150C turns off both FETs
// - Timer restarts on new cycle and enable writes
// - Double timer halves count rate while limiting
`timescale 1ns/1ps

module lics_sequencer #(
    parameter int unsigned IMMUNITY_CYCLES   = lics_pkg::IMMUNITY_CYC,
    parameter int unsigned TERM_DELAY_CYCLES = lics_pkg::TERM_DELAY_CYC,
    parameter int unsigned SEC_TICK_CYCLES   = lics_pkg::SEC_TICK_CYC
) (
    input  wire logic              sys_clk,
    input  wire logic              srst,
    input  wire lics_pkg::lics_cmp_s cmp_async,
    input  wire lics_pkg::lics_cfg_s cfg,
    output lics_pkg::lics_drv_s    drv,
    output lics_pkg::lics_sts_s    sts,
    output logic                   settings_reset,
    output logic                   host_ready
);
    import lics_pkg::*;

    localparam int CW = $bits(lics_cmp_s);

    // Three-stage synchroniser; a change counts once stages two and three agree
    logic [CW-1:0] sync1_q, sync2_q, sync3_q, cmp_q;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
            cmp_q   <= '0;
        end else begin
            sync1_q <= cmp_async;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            for (int i = 0; i < CW; i++) begin
                if (sync2_q[i] == sync3_q[i]) begin
                    cmp_q[i] <= sync3_q[i];
                end
            end
        end
    end

    lics_cmp_s c;
    assign c = lics_cmp_s'(cmp_q);

    logic in_present;
    logic in_normal;
    assign in_present = c.in_undervoltage_lockout_ok;
    assign in_normal  = c.in_undervoltage_lockout_ok && !c.in_ovp;

    // Supply-rise detection: clear settings when either rail passes lockout while neither was above it
    logic supply_up_q;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            supply_up_q <= 1'b0;
        end else begin
            supply_up_q <= c.in_undervoltage_lockout_ok || c.batt_undervoltage_lockout_ok;
        end
    end
    logic supply_rise;
    assign supply_rise = (c.in_undervoltage_lockout_ok || c.batt_undervoltage_lockout_ok) && !supply_up_q;
    assign settings_reset = supply_rise;
    assign host_ready     = supply_up_q;

    // Input immunity timer
    logic [31:0] imm_cnt_q;
    logic        input_good_q;
    always_ff @(posedge sys_clk) begin
        if (srst || !in_normal) begin
            imm_cnt_q    <= '0;
            input_good_q <= 1'b0;
        end else if (!input_good_q) begin
            if (imm_cnt_q >= 32'(IMMUNITY_CYCLES - 1)) begin
                input_good_q <= 1'b1;
            end else begin
                imm_cnt_q <= imm_cnt_q + 32'h1;
            end
        end
    end

    // Edge detection on host bits and input good that restart the safety timer
    logic ce_prev_q, te_prev_q, sr_prev_q, ingood_prev_q;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ce_prev_q     <= 1'b0;
            te_prev_q     <= 1'b0;
            sr_prev_q     <= 1'b0;
            ingood_prev_q <= 1'b0;
        end else begin
            ce_prev_q     <= cfg.charge_enable;
            te_prev_q     <= cfg.timer_enable;
            sr_prev_q     <= cfg.sw_reset;
            ingood_prev_q <= input_good_q;
        end
    end
    logic ce_rise, cfg_restart, power_recycled;
    assign ce_rise        = cfg.charge_enable && !ce_prev_q;
    assign power_recycled = input_good_q && !ingood_prev_q;
    assign cfg_restart    = ce_rise || (cfg.timer_enable && !te_prev_q)
                          || (cfg.sw_reset && !sr_prev_q);

    // Fault conditions
    logic charge_allowed;
    logic timeout_q;
    assign charge_allowed = !c.ntc_fault && !timeout_q && !c.batt_ovp
                          && !cfg.battery_fet_force_off && cfg.charge_enable;

    lics_phase_e phase_q;
    logic        auto_recharge;
    logic        new_cycle;
    logic        term_event;
    assign auto_recharge = (phase_q == LICS_DONE) && c.batt_below_rech && in_normal
                         && cfg.cutoff_enable && !cfg.done_without_cutoff;
    assign new_cycle = power_recycled || ce_rise || auto_recharge;

    // Seconds prescaler; with double timer the safety count steps at half rate while input limiting
    logic [31:0] pre_q;
    logic        half_q;
    logic        sec_tick;
    assign sec_tick = (pre_q >= 32'(SEC_TICK_CYCLES - 1));
    always_ff @(posedge sys_clk) begin
        if (srst || new_cycle || cfg_restart) begin
            pre_q  <= '0;
            half_q <= 1'b0;
        end else if (sec_tick) begin
            pre_q  <= '0;
            half_q <= !half_q;
        end else begin
            pre_q <= pre_q + 32'h1;
        end
    end
    logic timer_step;
    assign timer_step = sec_tick && (!(cfg.double_timer_enable && c.in_limiting)
                                     || half_q);

    // Safety timer counted in seconds; pre-charge and fast limits differ
    logic [31:0] safety_q;
    logic        pre_phase;
    assign pre_phase = (phase_q == LICS_PRE);
    always_ff @(posedge sys_clk) begin
        if (srst || new_cycle || cfg_restart) begin
            safety_q <= '0;
        end else if (phase_q == LICS_PRE || phase_q == LICS_FAST
                     || phase_q == LICS_CV) begin
            if (timer_step) begin
                safety_q <= safety_q + 32'h1;
            end
        end
    end
    logic timer_expired;
    assign timer_expired = cfg.timer_enable &&
        (pre_phase ? (safety_q >= 32'(PRECHARGE_SEC))
                   : (safety_q >= lics_fast_limit(cfg.fast_timer_sel)));

    // Termination delay: threshold must hold while CV dominates
    logic [31:0] term_cnt_q;
    always_ff @(posedge sys_clk) begin
        if (srst || phase_q != LICS_CV || !(c.cur_below_term && c.cv_dominant)) begin
            term_cnt_q <= '0;
        end else if (!term_event) begin
            term_cnt_q <= term_cnt_q + 32'h1;
        end
    end
    assign term_event = (term_cnt_q >= 32'(TERM_DELAY_CYCLES));

    logic done_flag_q;

    // Phase machine
    always_ff @(posedge sys_clk) begin
        if (srst || !input_good_q) begin
            phase_q <= LICS_IDLE;
        end else begin
            case (phase_q)
                LICS_IDLE: begin
                    if (new_cycle && charge_allowed) begin
                        phase_q <= c.batt_above_pre ? LICS_FAST : LICS_PRE;
                    end
                end

                LICS_PRE: begin
                    if (!charge_allowed) begin
                        phase_q <= LICS_FAULT;
                    end else if (timer_expired) begin
                        phase_q <= LICS_FAULT;
                    end else if (c.batt_above_pre) begin
                        phase_q <= LICS_FAST;
                    end
                end

                LICS_FAST: begin
                    if (!charge_allowed || timer_expired) begin
                        phase_q <= LICS_FAULT;
                    end else if (c.batt_at_full) begin
                        phase_q <= LICS_CV;
                    end
                end

                LICS_CV: begin
                    if (!charge_allowed || timer_expired) begin
                        phase_q <= LICS_FAULT;
                    end else if (term_event && cfg.cutoff_enable
                                 && !cfg.done_without_cutoff) begin
                        phase_q <= LICS_DONE;
                    end
                end

                LICS_DONE: begin
                    if (auto_recharge && charge_allowed) begin
                        phase_q <= c.batt_above_pre ? LICS_FAST : LICS_PRE;
                    end
                end

                LICS_FAULT: begin
                    // NTC and OVER_VOLTAGE_PROTECTION recover on their own; timeout needs a new cycle or restart write
                    if (charge_allowed) begin
                        phase_q <= c.batt_above_pre ? LICS_FAST : LICS_PRE;
                    end else if (new_cycle && !c.ntc_fault && !c.batt_ovp) begin
                        phase_q <= LICS_IDLE;
                    end
                end

                default: phase_q <= LICS_IDLE;
            endcase
        end
    end

    // Timeout fault latches until a fresh cycle or restart write
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            timeout_q <= 1'b0;
        end else if (timer_expired && (pre_phase || phase_q == LICS_FAST
                                       || phase_q == LICS_CV)) begin
            timeout_q <= 1'b1;
        end else if (new_cycle || cfg_restart) begin
            timeout_q <= 1'b0;
        end
    end

    // Charge Done while tapering continues
    always_ff @(posedge sys_clk) begin
        if (srst || phase_q == LICS_IDLE || phase_q == LICS_PRE
            || phase_q == LICS_FAST || !cfg.cutoff_enable) begin
            done_flag_q <= 1'b0;
        end else if (term_event && cfg.done_without_cutoff) begin
            done_flag_q <= 1'b1;
        end
    end

    // Supplement hysteresis
    logic supp_q;
    always_ff @(posedge sys_clk) begin
        if (srst || !in_present) begin
            supp_q <= 1'b0;
        end else if (c.sys_below_batt30) begin
            supp_q <= 1'b1;
        end else if (c.sys_above_batt20) begin
            supp_q <= 1'b0;
        end
    end

    // Output registers
    logic charging;
    assign charging = (phase_q == LICS_PRE) || (phase_q == LICS_FAST)
                    || (phase_q == LICS_CV);
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            drv <= '0;
            sts <= '0;
        end else begin
            drv.input_path_fet      <= input_good_q && in_normal
                                     && !c.tj_shutdown;

            drv.battery_fet         <= !c.tj_shutdown && !c.batt_ovp
                                     && !cfg.battery_fet_force_off
                                     && (charging || supp_q || !in_present);

            drv.battery_fet_full_on <= !c.tj_shutdown && !cfg.battery_fet_force_off
                                     && (!in_present || supp_q);

            drv.supplement_mode     <= supp_q;

            drv.discharge_mode      <= !in_present;

            drv.cc_mode             <= (phase_q == LICS_PRE) || (phase_q == LICS_FAST);

            drv.cv_mode             <= (phase_q == LICS_CV);

            drv.reduce_current      <= c.tj_at_reg;

            drv.current_field       <= cfg.precharge_current;

            drv.fast_current        <= cfg.fast_current;

            drv.full_charge_voltage <= cfg.full_charge_voltage;

            drv.term_threshold      <= cfg.fast_current[FAST_CUR_MSB]
                                     ? {cfg.term_current, 1'b0}
                                     : {1'b0, cfg.term_current};

            drv.tj_reg_sel          <= cfg.tj_reg_sel;

            sts.charging            <= charging && !done_flag_q;

            sts.charge_done         <= (phase_q == LICS_DONE) || done_flag_q;

            sts.timeout_fault       <= timeout_q;

            sts.batt_ovp_fault      <= c.batt_ovp;

            sts.thermal_fault       <= c.tj_shutdown;

            sts.input_fault         <= in_present && !in_normal;

            sts.phase               <= phase_q;
        end
    end

endmodule

// ### test/lics_host_model.sv
// Host-side settings store that feeds the sequencer configuration port.
// Assumes the bench posts whole settings words through a one-cycle write strobe.
`timescale 1ns/1ps
module lics_host_model (
    input  wire logic                sys_clk,
    input  wire logic                srst,
    input  wire logic                settings_reset,
    input  wire logic                wr,
    input  wire lics_pkg::lics_cfg_s wr_cfg,
    output lics_pkg::lics_cfg_s      cfg
);
    import lics_pkg::*;
    // Timer select default is arbitrary; enables follow the plain charge mode
    localparam lics_cfg_s CFG_RST = '{1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 2'h1,
        PRE_CUR_RST, FAST_CUR_RST, FULL_V_RST, TERM_CUR_RST, TJ_REG_RST};

    // Minimum input setting is assumed kept well above full voltage by the host
    always_ff @(posedge sys_clk) begin
        if (srst || settings_reset) begin
            cfg <= CFG_RST;
        end else if (wr) begin
            cfg <= wr_cfg;
        end
    end
endmodule

// ### test/lics_checker.sv
// Assertions on the charge sequencer ports, attached by bind.
// Assumes comparator inputs are held for several cycles whenever they change.
`timescale 1ns/1ps
module lics_checker #(
    parameter int unsigned IMMUNITY_CYCLES   = 8,
    parameter int unsigned TERM_DELAY_CYCLES = 10
) (
    input wire logic                sys_clk,
    input wire logic                srst,
    input wire lics_pkg::lics_cmp_s cmp_async,
    input wire lics_pkg::lics_cfg_s cfg,
    input wire lics_pkg::lics_drv_s drv,
    input wire lics_pkg::lics_sts_s sts,
    input wire logic                settings_reset,
    input wire logic                host_ready
);
    import lics_pkg::*;
    logic [31:0] good_q;
    logic [31:0] term_q;

    // Raw counts lead the synchronised ones, so they bound the design from above
    always_ff @(posedge sys_clk) begin
        if (srst || !cmp_async.in_undervoltage_lockout_ok || cmp_async.in_ovp) begin
            good_q <= 32'h0;
        end else if (good_q != 32'hFFFFFFFF) begin
            good_q <= good_q + 32'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst || !(cmp_async.cur_below_term && cmp_async.cv_dominant)) begin
            term_q <= 32'h0;
        end else if (term_q != 32'hFFFFFFFF) begin
            term_q <= term_q + 32'h1;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    sequence ovp_held_s;
        cmp_async.in_ovp [*8];
    endsequence
    sequence hot_held_s;
        cmp_async.tj_shutdown [*8];
    endsequence
    sequence no_input_s;
        (!cmp_async.in_undervoltage_lockout_ok && cmp_async.batt_undervoltage_lockout_ok && !cmp_async.tj_shutdown) [*8];
    endsequence

    fet_ovp_off_a: assert property (ovp_held_s |-> !drv.input_path_fet)
        else $error("input FET on during input over-voltage");
    fet_immunity_a: assert property ($rose(drv.input_path_fet) |-> good_q >= IMMUNITY_CYCLES)
        else $error("input FET on before immunity time");
    hot_fets_off_a: assert property (hot_held_s |-> !drv.input_path_fet && !drv.battery_fet)
        else $error("FET on during thermal shutdown");
    discharge_full_a: assert property (no_input_s |-> drv.discharge_mode && drv.battery_fet_full_on)
        else $error("battery FET not fully on without input");
    settings_pulse_a: assert property (settings_reset |=> !settings_reset ##[0:1] host_ready)
        else $error("settings reset pulse or host ready wrong");
    term_delay_a: assert property ($rose(sts.charge_done) |-> term_q >= TERM_DELAY_CYCLES)
        else $error("charge done before termination delay");
    no_cutoff_a: assert property (!cfg.cutoff_enable && !$past(cfg.cutoff_enable) |-> !$rose(sts.charge_done))
        else $error("charge done with cutoff disabled");
    term_level_a: assert property ($stable(cfg) [*3] |-> drv.term_threshold ==
        (cfg.fast_current[FAST_CUR_MSB] ? {cfg.term_current, 1'h0} : {1'h0, cfg.term_current}))
        else $error("termination threshold scaling wrong");
    ntc_stop_a: assert property (cmp_async.ntc_fault [*8] |-> !sts.charging)
        else $error("charging during thermistor fault");
    batt_ovp_stop_a: assert property (cmp_async.batt_ovp [*8] |-> !sts.charging)
        else $error("charging during battery over-voltage");
    tj_reduce_a: assert property (cmp_async.tj_at_reg [*8] |-> drv.reduce_current)
        else $error("current not reduced at regulation temperature");
endmodule

bind lics_sequencer lics_checker #(
    .IMMUNITY_CYCLES  (IMMUNITY_CYCLES),
    .TERM_DELAY_CYCLES(TERM_DELAY_CYCLES)
) i_chk (.sys_clk(sys_clk), .srst(srst), .cmp_async(cmp_async), .cfg(cfg), .drv(drv),
    .sts(sts), .settings_reset(settings_reset), .host_ready(host_ready));

// ### test/lics_testbench.sv
// Self-checking bench for the charge sequencer with a host settings model.
// Assumes shortened timers; comparator levels are driven directly by the bench.
`timescale 1ns/1ps
module testbench;
    import lics_pkg::*;
    localparam int unsigned IMM = 8;
    localparam int unsigned TDL = 10;
    localparam int unsigned TCK = 4;
    typedef struct packed {
        logic [4:0] fc;
        logic [1:0] tc;
        logic [1:0] tj;
        logic [2:0] th;
    } lics_row_s;
    lics_row_s rows [4] = '{'{5'h10, 2'h3, 2'h0, 3'h6}, '{5'h0F, 2'h3, 2'h1, 3'h3},
                            '{5'h1F, 2'h1, 2'h2, 3'h2}, '{5'h00, 2'h2, 2'h3, 3'h2}};
    logic      sys_clk;
    logic      srst;
    logic      wr;
    logic      settings_reset;
    logic      host_ready;
    lics_cmp_s cmp;
    lics_cfg_s cfg;
    lics_cfg_s c;
    lics_drv_s drv;
    lics_sts_s sts;
    int        num_errors;
    int        comparisons;
    int        n;

    lics_sequencer #(.IMMUNITY_CYCLES(IMM), .TERM_DELAY_CYCLES(TDL), .SEC_TICK_CYCLES(TCK))
        i_dut (.sys_clk(sys_clk), .srst(srst), .cmp_async(cmp), .cfg(cfg), .drv(drv),
        .sts(sts), .settings_reset(settings_reset), .host_ready(host_ready));
    lics_host_model i_host (.sys_clk(sys_clk), .srst(srst), .settings_reset(settings_reset),
        .wr(wr), .wr_cfg(c), .cfg(cfg));

    task automatic complete_run();
        if (num_errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(negedge sys_clk);
    endtask

    task automatic guard(input int k, input int lim);
        if (k >= lim) begin
            num_errors++;
            $display("MISMATCH %0t wait limit reached", $time);
            complete_run();
        end
    endtask

    task automatic host_wr();
        wr = 1'h1;
        tick(1);
        wr = 1'h0;
    endtask

    task automatic wait_phase(input lics_phase_e p);
        n = 0;
        while (sts.phase !== p && n < 200) begin
            tick(1);
            n++;
        end
        guard(n, 200);
        chk(32'(sts.phase), 32'(p));
    endtask

    initial begin
        sys_clk = 1'h0;
        forever #4 sys_clk = ~sys_clk;
    end

    initial begin
        num_errors = 0;
        comparisons = 0;
        cmp = '0;
        wr = 1'h0;
        c = '0;
        srst = 1'h1;
        tick(8);
        chk(32'(drv), 32'h0);
        chk(32'(sts), 32'h0);
        srst = 1'h0;
        cmp.batt_undervoltage_lockout_ok = 1'h1;
        n = 0;
        while (settings_reset !== 1'h1 && n < 20) begin
            tick(1);
            n++;
        end
        guard(n, 20);
        tick(3);
        chk(32'(host_ready), 32'h1);
        tick(10);
        chk(32'({drv.discharge_mode, drv.battery_fet_full_on}), 32'h3);
        // Input good too briefly must leave the input FET off
        cmp.in_undervoltage_lockout_ok = 1'h1;
        tick(IMM / 2);
        cmp.in_undervoltage_lockout_ok = 1'h0;
        tick(20);
        chk(32'(drv.input_path_fet), 32'h0);
        cmp.in_undervoltage_lockout_ok = 1'h1;
        n = 0;
        while (drv.input_path_fet !== 1'h1 && n < 100) begin
            tick(1);
            n++;
        end
        guard(n, 100);
        chk(32'(n >= IMM && n <= IMM + 12), 32'h1);
        wait_phase(LICS_PRE);
        chk(32'({sts.charging, drv.current_field}), 32'({1'h1, cfg.precharge_current}));
        c = cfg;
        foreach (rows[i]) begin
            c.fast_current = rows[i].fc;
            c.term_current = rows[i].tc;
            c.tj_reg_sel = rows[i].tj;
            host_wr();
            tick(3);
            chk(32'(drv.term_threshold), 32'(rows[i].th));
            chk(32'(drv.tj_reg_sel), 32'(rows[i].tj));
            chk(32'(drv.fast_current), 32'(rows[i].fc));
        end
        cmp.sys_below_batt30 = 1'h1;
        tick(8);
        chk(32'(drv.supplement_mode), 32'h1);
        cmp.sys_below_batt30 = 1'h0;
        tick(8);
        chk(32'(drv.supplement_mode), 32'h1);
        cmp.sys_above_batt20 = 1'h1;
        tick(8);
        chk(32'(drv.supplement_mode), 32'h0);
        cmp.sys_above_batt20 = 1'h0;
        cmp.tj_at_reg = 1'h1;
        tick(8);
        chk(32'(drv.reduce_current), 32'h1);
        cmp.tj_at_reg = 1'h0;
        cmp.batt_above_pre = 1'h1;
        wait_phase(LICS_FAST);
        chk(32'(drv.cc_mode), 32'h1);
        cmp.batt_at_full = 1'h1;
        wait_phase(LICS_CV);
        chk(32'({drv.cc_mode, drv.cv_mode}), 32'h1);
        cmp.cv_dominant = 1'h1;
        // First without cutoff, then with cutoff, which must end in the done phase
        for (int m = 0; m < 2; m++) begin
            c.cutoff_enable = 1'(m);
            host_wr();
            cmp.cur_below_term = 1'h1;
            tick(TDL + 12);
            chk(32'({sts.charge_done, sts.charging}), m ? 32'h2 : 32'h1);
            cmp.cur_below_term = 1'h0;
            tick(8);
        end
        chk(32'(sts.phase), 32'(LICS_DONE));
        cmp.batt_at_full = 1'h0;
        cmp.batt_below_rech = 1'h1;
        wait_phase(LICS_FAST);
        chk(32'(sts.charging), 32'h1);
        cmp.batt_below_rech = 1'h0;
        c.done_without_cutoff = 1'h1;
        host_wr();
        cmp.batt_at_full = 1'h1;
        wait_phase(LICS_CV);
        cmp.cur_below_term = 1'h1;
        tick(TDL + 12);
        chk(32'({sts.charge_done, drv.cv_mode}), 32'h3);
        cmp.cur_below_term = 1'h0;
        c.charge_enable = 1'h0;
        host_wr();
        tick(2);
        c.charge_enable = 1'h1;
        host_wr();
        wait_phase(LICS_CV);
        cmp.ntc_fault = 1'h1;
        tick(10);
        chk(32'(sts.charging), 32'h0);
        cmp.ntc_fault = 1'h0;
        tick(10);
        chk(32'(sts.charging), 32'h1);
        cmp.batt_ovp = 1'h1;
        tick(10);
        chk(32'({sts.batt_ovp_fault, sts.charging}), 32'h2);
        cmp.batt_ovp = 1'h0;
        cmp.in_ovp = 1'h1;
        tick(8);
        chk(32'({drv.input_path_fet, sts.input_fault}), 32'h1);
        cmp.in_ovp = 1'h0;
        tick(IMM + 16);
        chk(32'(drv.input_path_fet), 32'h1);
        cmp.tj_shutdown = 1'h1;
        tick(8);
        chk(32'({drv.input_path_fet, drv.battery_fet, sts.thermal_fault}), 32'h1);
        cmp.tj_shutdown = 1'h0;
        tick(IMM + 16);
        // Low battery after a fresh enable runs into the pre-charge time limit
        cmp.batt_at_full = 1'h0;
        cmp.batt_above_pre = 1'h0;
        c.charge_enable = 1'h0;
        host_wr();
        tick(2);
        c.charge_enable = 1'h1;
        host_wr();
        wait_phase(LICS_PRE);
        n = 0;
        while (sts.timeout_fault !== 1'h1 && n < 40000) begin
            tick(1);
            n++;
        end
        guard(n, 40000);
        chk(32'(n + 50 >= PRECHARGE_SEC * TCK && n <= PRECHARGE_SEC * TCK + 50), 32'h1);
        chk(32'(sts.charging), 32'h0);
        complete_run();
    end
endmodule
